// File: common/icw_pkg.sv
// Purpose: shared constants and types of the internal counter watchdog
// Assumes: byte wide register port, 16-bit register addresses
// Notes:   event bits are shared by the status and mask registers

package icw_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] ICW_CTRL_ADDR   = 16'hFE79;
  localparam logic [15:0] ICW_STATUS_ADDR = 16'hFE7A;
  localparam logic [15:0] ICW_MASK_ADDR   = 16'hFE7B;
  localparam logic [15:0] ICW_CNT_LO_ADDR = 16'hFE7C;
  localparam logic [15:0] ICW_CNT_HI_ADDR = 16'hFE7D;

  // ---------------------------------------------------------------
  // control register layout and values
  // ---------------------------------------------------------------
  localparam int          ICW_FLAG_BIT   = 7;
  localparam int          ICW_TEST_BIT   = 6;
  localparam int          ICW_RUN_BIT    = 5;
  localparam int          ICW_STBY_HI    = 4;
  localparam int          ICW_STBY_LO    = 3;
  localparam int          ICW_SEL_MSB    = 2;
  localparam logic [7:0]  ICW_CTRL_RESET = 8'h00;
  localparam logic [7:0]  ICW_KEEP_MASK  = 8'h1F;
  localparam logic [7:0]  ICW_FLAG_MASK  = 8'h80;
  localparam logic [7:0]  ICW_CLEAR_KEY  = 8'h55;
  localparam logic [15:0] ICW_CNT_RESET  = 16'h0000;

  // smallest selectable overflow count, code 000
  localparam logic [16:0] ICW_BASE_COUNT = 17'h00200;

  // ---------------------------------------------------------------
  // event bits in status and mask
  // ---------------------------------------------------------------
  localparam int          ICW_EV_OVF     = 0;
  localparam int          ICW_EV_REFUSED = 1;
  localparam int          ICW_EV_W       = 2;
  localparam logic [1:0]  ICW_EV_RESET   = 2'h0;

  // ---------------------------------------------------------------
  // standby behaviour
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ICW_STBY_CONTINUE,
    ICW_STBY_STOP,
    ICW_STBY_HOLD
  } icw_stby_type;

endpackage

// File: rtl/icw_rc_tick.sv
// Purpose: turns the sampled rc oscillator level into one-cycle ticks
// Assumes: rc level is synchronous to clk and far slower than clk
// Notes:   one tick per rising edge of the rc level

`timescale 1ns/100ps

module icw_rc_tick
  import icw_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // rc oscillator level and resulting tick
  input  wire logic rc_level,
  output logic      rc_tick
);

  typedef struct packed {
    logic prev;
  } icw_tick_state_type;

  icw_tick_state_type tick_reg;
  icw_tick_state_type tick_next;

  always_comb begin
    tick_next      = tick_reg;
    tick_next.prev = rc_level;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_reg <= '0;
    end else if (ce) begin
      tick_reg <= tick_next;
    end
  end

  // frozen while ce is low, so no tick leaks out then
  assign rc_tick = ce & rc_level & ~tick_reg.prev;

endmodule

// File: rtl/icw_watchdog.sv
// Purpose: watchdog with a 16-bit up-counter driven by rc oscillator ticks
// Assumes: rst is the external reset pin, already inverted to active high
// Notes:   one register port, one level interrupt, one reset pulse out
//
// Operation
// - 16-bit up-counter advances on every tick of the low-speed rc clock.
// - overflow when the count equals the level chosen by bits 2..0.
// - codes 000..111 select 512, 1024, ... up to 65536 ticks.
// - overflow raises internal reset, sets flag bit 7, clears run bit.
// - external reset clears the whole control register to 00H.
// - watchdog reset keeps control bits 4..0 unchanged.
// - once running, ordinary writes to control are ignored.
// - immediate-move write of 55H while running clears and restarts count.
// - run bit 1 starts watchdog and oscillator; 0, set only by a reset, stops both.
// - bits 4..3: 00 continue, 01 stop, 10 hold, 11 continue.
// - hold mode freezes the count in standby, resumes after exit.
// - continue mode keeps oscillator and counter going in standby.
// - count held zero when stopped, on overflow, clear, stop standby.
// - reset flag set by watchdog reset, software may write it.
// - counting needs clk running with ce high; the counter freezes while ce is low.

`timescale 1ns/100ps

module icw_watchdog
  import icw_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_wr_immediate,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // system state and rc oscillator
  input  wire logic        standby,
  input  wire logic        rc_level,
  output logic             rc_osc_en,
  // results
  output logic             wdt_reset,
  output logic             irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]          ctrl;
    logic [15:0]         count;
    logic [ICW_EV_W-1:0] irq_status;
    logic [ICW_EV_W-1:0] irq_mask;
    logic [7:0]          rdata;
    logic                wdt_reset;
  } icw_state_type;

  icw_state_type state_reg;
  icw_state_type state_next;

  logic          rc_tick;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic icw_stby_type stby_mode(input logic [7:0] ctrl);
    logic [1:0] code;
    code = {ctrl[ICW_STBY_HI], ctrl[ICW_STBY_LO]};
    unique case (code)
      2'h1:    stby_mode = ICW_STBY_STOP;
      2'h2:    stby_mode = ICW_STBY_HOLD;
      default: stby_mode = ICW_STBY_CONTINUE;
    endcase
  endfunction

  // shifting the base count gives the eight powers of two
  function automatic logic [16:0] limit_of(input logic [2:0] sel);
    limit_of = ICW_BASE_COUNT << sel;
  endfunction

  // true while the rc oscillator is allowed to run
  function automatic logic osc_allowed(input logic [7:0] ctrl,
                                       input logic       stby);
    osc_allowed = ctrl[ICW_RUN_BIT] &
                  (~stby | (stby_mode(ctrl) == ICW_STBY_CONTINUE));
  endfunction

  // ---------------------------------------------------------------
  // rc tick
  // ---------------------------------------------------------------
  // the rc level is sampled in the clk domain, so every command below
  // meets the counter in one domain and needs no crossing
  icw_rc_tick u_tick (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .rc_level (rc_level),
    .rc_tick  (rc_tick)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    icw_stby_type mode;
    logic         running;
    logic         ctrl_wr;
    logic         clear_cmd;
    logic         refused;
    logic         overflow;
    logic [16:0]  next_count;

    state_next           = state_reg;
    state_next.wdt_reset = 1'b0;
    state_next.rdata     = 8'h00;
    mode       = stby_mode(state_reg.ctrl);
    running    = state_reg.ctrl[ICW_RUN_BIT];
    ctrl_wr    = reg_wr & (reg_addr == ICW_CTRL_ADDR);
    clear_cmd  = 1'b0;
    refused    = 1'b0;
    overflow   = 1'b0;
    next_count = {1'b0, state_reg.count} + 17'h00001;

    // control writes
    if (ctrl_wr) begin
      if (!running) begin
        // flag and every field open while stopped
        state_next.ctrl = reg_wdata;
      end else if (reg_wr_immediate && (reg_wdata == ICW_CLEAR_KEY)) begin
        clear_cmd = 1'b1;
      end else begin
        // a stop request is refused too; only reset ends a run
        refused = 1'b1;
      end
    end

    // counter
    if (!running) begin
      state_next.count = ICW_CNT_RESET;
    end else if (clear_cmd) begin
      state_next.count = ICW_CNT_RESET;
    end else if (standby && (mode == ICW_STBY_STOP)) begin
      state_next.count = ICW_CNT_RESET;
    end else if (standby && (mode == ICW_STBY_HOLD)) begin
      state_next.count = state_reg.count;
    end else if (rc_tick) begin
      // no term here looks at the system side, only at the rc tick
      if (next_count == limit_of(state_reg.ctrl[ICW_SEL_MSB:0])) begin
        overflow = 1'b1;
      end else begin
        state_next.count = next_count[15:0];
      end
    end

    // overflow: reset out, flag set, run and test bit cleared
    if (overflow) begin
      state_next.count     = ICW_CNT_RESET;
      state_next.ctrl      = (state_reg.ctrl & ICW_KEEP_MASK) |
                             ICW_FLAG_MASK;
      state_next.wdt_reset = 1'b1;
    end

    // interrupt status: write one to clear, a new event wins
    if (reg_wr && (reg_addr == ICW_STATUS_ADDR)) begin
      state_next.irq_status = state_reg.irq_status &
                              ~reg_wdata[ICW_EV_W-1:0];
    end
    if (overflow) begin
      state_next.irq_status[ICW_EV_OVF] = 1'b1;
    end
    if (refused) begin
      state_next.irq_status[ICW_EV_REFUSED] = 1'b1;
    end

    // interrupt mask
    if (reg_wr && (reg_addr == ICW_MASK_ADDR)) begin
      state_next.irq_mask = reg_wdata[ICW_EV_W-1:0];
    end

    // read data, unmapped addresses read zero
    if (reg_rd) begin
      unique case (reg_addr)
        ICW_CTRL_ADDR: begin
          state_next.rdata = state_reg.ctrl;
        end
        ICW_STATUS_ADDR: begin
          state_next.rdata = {6'h00, state_reg.irq_status};
        end
        ICW_MASK_ADDR: begin
          state_next.rdata = {6'h00, state_reg.irq_mask};
        end
        ICW_CNT_LO_ADDR: begin
          state_next.rdata = state_reg.count[7:0];
        end
        ICW_CNT_HI_ADDR: begin
          state_next.rdata = state_reg.count[15:8];
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg            <= '0;
      state_reg.ctrl       <= ICW_CTRL_RESET;
      state_reg.count      <= ICW_CNT_RESET;
      state_reg.irq_status <= ICW_EV_RESET;
      state_reg.irq_mask   <= ICW_EV_RESET;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata = state_reg.rdata;
  assign wdt_reset = state_reg.wdt_reset;
  assign irq       = |(state_reg.irq_status & state_reg.irq_mask);
  // oscillator off when stopped and in stop or hold standby
  assign rc_osc_en = osc_allowed(state_reg.ctrl, standby);

endmodule

// File: verif/icw_watchdog_asserts.sv
// Purpose: port-level checks of the watchdog
// Assumes: one clock domain, rst active high
// Notes:   sees only the top module ports
`timescale 1ns/100ps

module icw_watchdog_asserts
  import icw_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_wr_immediate,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // system state and results
  input wire logic        standby,
  input wire logic        rc_level,
  input wire logic        rc_osc_en,
  input wire logic        wdt_reset,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_pulse_single:
    assert property (wdt_reset |=> !wdt_reset) else $error("long reset");
  a_run_before_reset:
    assert property (wdt_reset |-> $past(rc_osc_en)) else $error("no run");
  a_reset_stops_osc:
    assert property (wdt_reset |-> !rc_osc_en) else $error("osc kept");
  a_read_run_bit:
    assert property ($past(reg_rd) && $past(reg_addr) == ICW_CTRL_ADDR &&
      $past(ce) && !standby && !wdt_reset |->
      reg_rdata[ICW_RUN_BIT] == rc_osc_en) else $error("run vs osc");
  a_osc_rise_cause:
    assert property ($rose(rc_osc_en) |-> $past(reg_wr) || $fell(standby))
    else $error("osc rose alone");
  a_osc_fall_cause:
    assert property ($fell(rc_osc_en) |-> wdt_reset || $rose(standby))
    else $error("osc fell alone");
  a_irq_rise_cause:
    assert property ($rose(irq) |-> wdt_reset || $past(reg_wr))
    else $error("irq rose alone");
  a_irq_fall_cause:
    assert property ($fell(irq) |-> $past(reg_wr)) else $error("irq fell");
endmodule

bind icw_watchdog icw_watchdog_asserts u_icw_watchdog_asserts (
  .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wr_immediate(reg_wr_immediate), .reg_rdata(reg_rdata),
  .standby(standby), .rc_level(rc_level), .rc_osc_en(rc_osc_en),
  .wdt_reset(wdt_reset), .irq(irq));

// File: verif/icw_watchdog_tb.sv
// Purpose: self-checking bench of the watchdog
// Assumes: ce high except one freeze check, one rc tick every two clocks
// Notes:   codes 4 to 7 too long to reach, only checked not to trip early
`timescale 1ns/100ps

module icw_watchdog_tb
  import icw_pkg::*;
;
  logic        clk, rst, ce, reg_wr, reg_wr_immediate, reg_rd;
  logic        standby, rc_level, rc_osc_en, wdt_reset, irq;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  int          num_errors, n_compared, n_rst, cycles, n_base;
  logic [32:0] rows [10];
  logic [7:0]  m_ctrl [4], m_hold [4], m_after [4], m_osc [4];

  icw_watchdog u_icw_watchdog (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wr_immediate(reg_wr_immediate), .reg_rdata(reg_rdata),
    .standby(standby), .rc_level(rc_level), .rc_osc_en(rc_osc_en),
    .wdt_reset(wdt_reset), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // guards against a hang, well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (wdt_reset === 1'b1) n_rst++;
    if (cycles == 40000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic i);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_immediate <= i;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wr_immediate <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      rc_level <= 1'b1;
      @(posedge clk);
      rc_level <= 1'b0;
    end
  endtask

  task automatic ovf_check(input logic [2:0] sel, input logic [7:0] exp);
    int base;
    base = n_rst;
    ticks((512 << sel) - 1);
    repeat (4) @(posedge clk);
    chk(8'(n_rst - base), 8'h00);
    ticks(1);
    repeat (4) @(posedge clk);
    chk(8'(n_rst - base), 8'h01);
    chk({7'h00, irq}, 8'h01);
    rd(ICW_CTRL_ADDR, exp);
    rd(ICW_CNT_LO_ADDR, 8'h00);
    wr(ICW_STATUS_ADDR, 8'h01, 1'b0);
    #1 chk({7'h00, irq}, 8'h00);
    wr(ICW_CTRL_ADDR, 8'h00, 1'b0);
    rd(ICW_CTRL_ADDR, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, ce} = 2'b11;
    {reg_wr, reg_wr_immediate, reg_rd, standby, rc_level} = 5'h00;
    {reg_addr, reg_wdata} = 24'h000000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rows = '{{1'b0, ICW_CTRL_ADDR, 16'h0000}, {1'b0, ICW_STATUS_ADDR, 16'h0},
      {1'b0, ICW_MASK_ADDR, 16'h0000}, {1'b1, ICW_CTRL_ADDR, 16'h9A00},
      {1'b0, ICW_CTRL_ADDR, 16'h009A}, {1'b1, ICW_MASK_ADDR, 16'h0100},
      {1'b0, ICW_MASK_ADDR, 16'h0001}, {1'b0, 16'hFE00, 16'h0000},
      {1'b1, ICW_CTRL_ADDR, 16'h0000}, {1'b0, ICW_CTRL_ADDR, 16'h0000}};
    foreach (rows[i]) begin
      if (rows[i][32]) wr(rows[i][31:16], rows[i][15:8], 1'b0);
      else rd(rows[i][31:16], rows[i][7:0]);
    end
    wr(ICW_CTRL_ADDR, 8'h20, 1'b0);
    #1 chk({7'h00, rc_osc_en}, 8'h01);
    wr(ICW_CTRL_ADDR, 8'h00, 1'b0);
    rd(ICW_CTRL_ADDR, 8'h20);
    rd(ICW_STATUS_ADDR, 8'h02);
    ticks(300);
    wr(ICW_CTRL_ADDR, ICW_CLEAR_KEY, 1'b0);
    rd(ICW_CNT_LO_ADDR, 8'h2C);
    rd(ICW_CNT_HI_ADDR, 8'h01);
    wr(ICW_CTRL_ADDR, ICW_CLEAR_KEY, 1'b1);
    rd(ICW_CNT_LO_ADDR, 8'h00);
    ovf_check(3'h0, 8'h80);
    for (int s = 1; s < 4; s++) begin
      wr(ICW_CTRL_ADDR, 8'h38 | 8'(s), 1'b0);
      ovf_check(3'(s), 8'h98 | 8'(s));
    end
    m_ctrl = '{8'h20, 8'h28, 8'h30, 8'h38};
    m_hold = '{8'h0A, 8'h00, 8'h06, 8'h0A};
    m_after = '{8'h0C, 8'h02, 8'h08, 8'h0C};
    m_osc = '{8'h01, 8'h00, 8'h00, 8'h01};
    foreach (m_ctrl[m]) begin
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      wr(ICW_CTRL_ADDR, m_ctrl[m], 1'b0);
      ticks(6);
      standby <= 1'b1;
      ticks(4);
      #1 chk({7'h00, rc_osc_en}, m_osc[m]);
      rd(ICW_CNT_LO_ADDR, m_hold[m]);
      @(posedge clk);
      standby <= 1'b0;
      ticks(2);
      rd(ICW_CNT_LO_ADDR, m_after[m]);
    end
    // long codes: must not trip at the 512-tick level of code 000
    for (int s = 4; s < 8; s++) begin
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      wr(ICW_CTRL_ADDR, 8'h20 | 8'(s), 1'b0);
      n_base = n_rst;
      ticks(520);
      repeat (4) @(posedge clk);
      chk(8'(n_rst - n_base), 8'h00);
      rd(ICW_CNT_HI_ADDR, 8'h02);
      rd(ICW_CNT_LO_ADDR, 8'h08);
      rd(ICW_CTRL_ADDR, 8'h20 | 8'(s));
    end
    // ce low: ticks must not reach the counter
    @(posedge clk);
    ce <= 1'b0;
    ticks(3);
    @(posedge clk);
    ce <= 1'b1;
    rd(ICW_CNT_LO_ADDR, 8'h08);
    finish_test();
  end
endmodule
